// ---- pvei_consts.vh ----
// constants for the printer video engine interface
`ifndef PVEI_CONSTS_VH
`define PVEI_CONSTS_VH
// ************************************************************
// register byte offsets
// ************************************************************
`define PVEI_REG_CTRL    8'h00
`define PVEI_REG_STAT    8'h04
`define PVEI_REG_MARGIN  8'h08
`define PVEI_REG_LINELEN 8'h0c
`define PVEI_REG_MADR    8'h10
`define PVEI_REG_MCNT    8'h14
`define PVEI_REG_CADR    8'h18
`define PVEI_REG_CCNT    8'h1c
`define PVEI_REG_PEL     8'h20
// ************************************************************
// control fields and reset values
// ************************************************************
`define PVEI_CTRL_EN     0
`define PVEI_CTRL_STR_LO 1
`define PVEI_CTRL_STR_HI 2
`define PVEI_CTRL_GREY   3
`define PVEI_CTRL_SHM_LO 4
`define PVEI_CTRL_SHM_HI 5
`define PVEI_CTRL_RST    8'h00
`define PVEI_STAT_URUN   2
`define PVEI_STR_1       2'h0
`define PVEI_STR_2       2'h1
`define PVEI_SHM_PIX     2'h0
`define PVEI_SHM_INV     2'h1
// ************************************************************
// sizes
// ************************************************************
`define PVEI_FIFO_DEPTH  4'h8
`define PVEI_BURST_MAX   24'h000010
`define PVEI_BURST_WORDS 4'h4
`define PVEI_WORD_BITS   6'h20
`define PVEI_WORD_BYTES  32'h00000004
`endif

// ---- pvei_top.v ----
// printer video engine interface: wishbone regs, video dma, fifo, serialiser
//
// Our own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pvei_consts.vh"
module pvei_top (
   input  wire        clk_i,
   input  wire        sys_rst_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [31:0] wb_dat_i,
   input  wire [3:0]  wb_sel_i,
   input  wire        wb_we_i,
   input  wire        wb_stb_i,
   input  wire        wb_cyc_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   output reg         dma_req_o,
   output reg  [31:0] dma_adr_o,
   output reg  [4:0]  dma_len_o,
   input  wire        dma_gnt_i,
   input  wire [31:0] dma_rdata_i,
   input  wire        dma_rvalid_i,
   output reg         dma_rready_o,
   input  wire        pixel_clock_in_i,
   input  wire        line_sync_in_i,
   input  wire        page_sync_in_i,
   output reg  [3:0]  video_o,
   output reg         shift_clock_out_o
);
   localparam D_IDLE = 2'h0, D_REQ = 2'h1, D_DATA = 2'h2;
   localparam V_IDLE = 2'h0, V_WAITL = 2'h1, V_HSKIP = 2'h2, V_ACT = 2'h3;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  sel;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
         end
      end
   endfunction

   function [2:0] ones4;
      input [3:0] v;
      begin
         ones4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
      end
   endfunction

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   reg [2:0] pix_r, lsy_r, psy_r;
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pix_r <= 3'h0;
         lsy_r <= 3'h0;
         psy_r <= 3'h0;
      end else begin
         pix_r <= {pix_r[1:0], pixel_clock_in_i};
         lsy_r <= {lsy_r[1:0], line_sync_in_i};
         psy_r <= {psy_r[1:0], page_sync_in_i};
      end
   end
   // edges look only at stages two and three
   wire pix_edge  = pix_r[1] & ~pix_r[2];
   wire line_edge = lsy_r[1] & ~lsy_r[2];
   wire page_edge = psy_r[1] & ~psy_r[2];

   // ************************************************************
   // registers
   // ************************************************************
   reg  [7:0]  ctrl_r;
   reg  [31:0] margin_r, linelen_r, pel_r;
   reg  [31:0] m_adr_r, c_adr_r;
   reg  [23:0] m_cnt_r, c_cnt_r;
   reg         m_val_r, c_val_r, urun_r;
   reg  [1:0]  dst_r, vst_r;
   reg  [3:0]  fcnt_r;
   reg  [1:0]  bcnt_r;
   wire        wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        wb_wr  = wb_req & wb_we_i;
   wire [1:0]  streams = ctrl_r[`PVEI_CTRL_STR_HI:`PVEI_CTRL_STR_LO];
   wire [1:0]  shmode  = ctrl_r[`PVEI_CTRL_SHM_HI:`PVEI_CTRL_SHM_LO];
   wire        enable  = ctrl_r[`PVEI_CTRL_EN];
   wire        grey    = ctrl_r[`PVEI_CTRL_GREY];
   wire [31:0] ctrl_w  = merge({24'h0, ctrl_r}, wb_dat_i, wb_sel_i);
   reg  [31:0] rd_nxt;
   always @* begin
      case (wb_adr_i)
         `PVEI_REG_CTRL:    rd_nxt = {24'h0, ctrl_r};
         `PVEI_REG_STAT:    rd_nxt = {20'h0, fcnt_r, bcnt_r, vst_r, urun_r,
                                      c_val_r, m_val_r};
         `PVEI_REG_MARGIN:  rd_nxt = margin_r;
         `PVEI_REG_LINELEN: rd_nxt = linelen_r;
         `PVEI_REG_MADR:    rd_nxt = m_adr_r;
         `PVEI_REG_MCNT:    rd_nxt = {8'h0, m_cnt_r};
         `PVEI_REG_CADR:    rd_nxt = c_adr_r;
         `PVEI_REG_CCNT:    rd_nxt = {8'h0, c_cnt_r};
         `PVEI_REG_PEL:     rd_nxt = pel_r;
         default:           rd_nxt = 32'h0;
      endcase
   end
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wb_ack_o  <= 1'b0;
         wb_dat_o  <= 32'h0;
         ctrl_r    <= `PVEI_CTRL_RST;
         margin_r  <= 32'h0;
         linelen_r <= 32'h0;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_nxt : 32'h0;
         if (wb_wr && wb_adr_i == `PVEI_REG_CTRL)
            ctrl_r <= ctrl_w[7:0];
         if (wb_wr && wb_adr_i == `PVEI_REG_MARGIN)
            margin_r <= merge(margin_r, wb_dat_i, wb_sel_i);
         if (wb_wr && wb_adr_i == `PVEI_REG_LINELEN)
            linelen_r <= merge(linelen_r, wb_dat_i, wb_sel_i);
      end
   end

   // ************************************************************
   // video dma with chaining
   // ************************************************************
   reg  [31:0] buf0_r, buf1_r;
   reg  [2:0]  wleft_r;
   wire [23:0] blen = (m_cnt_r > `PVEI_BURST_MAX) ? `PVEI_BURST_MAX
                                                  : m_cnt_r;
   wire        room = ({2'h0, bcnt_r} + fcnt_r + `PVEI_BURST_WORDS)
                      <= `PVEI_FIFO_DEPTH;
   wire        take_in = dma_rvalid_i & dma_rready_o & (dst_r == D_DATA);
   wire        last_w  = take_in & (wleft_r == 3'h1);
   wire [31:0] madr_w = merge(m_adr_r, wb_dat_i, wb_sel_i);
   wire [31:0] mcnt_w = merge({8'h0, m_cnt_r}, wb_dat_i, wb_sel_i);
   wire [31:0] ccnt_w = merge({8'h0, c_cnt_r}, wb_dat_i, wb_sel_i);
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dst_r     <= D_IDLE;
         dma_req_o <= 1'b0;
         dma_adr_o <= 32'h0;
         dma_len_o <= 5'h0;
         wleft_r   <= 3'h0;
         m_adr_r   <= 32'h0;
         m_cnt_r   <= 24'h0;
         m_val_r   <= 1'b0;
         c_adr_r   <= 32'h0;
         c_cnt_r   <= 24'h0;
         c_val_r   <= 1'b0;
      end else begin
         case (dst_r)
            D_IDLE: begin
               if (enable && m_val_r && room) begin
                  dst_r     <= D_REQ;
                  dma_req_o <= 1'b1;
                  dma_adr_o <= m_adr_r;
                  dma_len_o <= blen[4:0];
                  wleft_r   <= blen[4:2] + {2'h0, |blen[1:0]};
               end
            end
            D_REQ: begin
               if (dma_gnt_i) begin
                  dma_req_o <= 1'b0;
                  dst_r     <= D_DATA;
               end
            end
            D_DATA: begin
               if (take_in)
                  wleft_r <= wleft_r - 3'h1;
               if (last_w) begin
                  dst_r   <= D_IDLE;
                  m_adr_r <= m_adr_r + {27'h0, dma_len_o};
                  if (m_cnt_r == {19'h0, dma_len_o}) begin
                     m_adr_r <= c_adr_r;
                     m_cnt_r <= c_cnt_r;
                     m_val_r <= c_val_r;
                     c_val_r <= 1'b0;
                  end else begin
                     m_cnt_r <= m_cnt_r - {19'h0, dma_len_o};
                  end
               end
            end
            default: dst_r <= D_IDLE;
         endcase
         // loads go only to an idle master or to the chain pair
         if (wb_wr && dst_r == D_IDLE) begin
            if (wb_adr_i == `PVEI_REG_MADR)
               m_adr_r <= madr_w;
            if (wb_adr_i == `PVEI_REG_MCNT) begin
               m_cnt_r <= mcnt_w[23:0];
               m_val_r <= |mcnt_w[23:0];
            end
         end
         if (wb_wr && wb_adr_i == `PVEI_REG_CADR)
            c_adr_r <= merge(c_adr_r, wb_dat_i, wb_sel_i);
         if (wb_wr && wb_adr_i == `PVEI_REG_CCNT) begin
            c_cnt_r <= ccnt_w[23:0];
            c_val_r <= |ccnt_w[23:0];
         end
      end
   end

   // ************************************************************
   // two-entry buffer and eight-word video fifo
   // ************************************************************
   reg  [31:0] fmem [0:7];
   reg  [2:0]  wp_r, rp_r;
   wire        b2f  = (bcnt_r != 2'h0) && (fcnt_r != `PVEI_FIFO_DEPTH);
   wire        fpop;
   wire [1:0]  bcnt_nxt = bcnt_r + {1'b0, take_in} - {1'b0, b2f};
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         buf0_r       <= 32'h0;
         buf1_r       <= 32'h0;
         bcnt_r       <= 2'h0;
         dma_rready_o <= 1'b0;
         wp_r         <= 3'h0;
         rp_r         <= 3'h0;
         fcnt_r       <= 4'h0;
      end else begin
         if (b2f)
            buf0_r <= buf1_r;
         if (take_in) begin
            if (bcnt_r == 2'h0 || (bcnt_r == 2'h1 && b2f)) begin
               buf0_r <= dma_rdata_i;
            end else begin
               buf1_r <= dma_rdata_i;
            end
         end
         bcnt_r       <= bcnt_nxt;
         dma_rready_o <= bcnt_nxt != 2'h2; // stall reaches the memory
         if (b2f) begin
            fmem[wp_r] <= buf0_r;
            wp_r       <= wp_r + 3'h1;
         end
         if (fpop)
            rp_r <= rp_r + 3'h1;
         fcnt_r <= fcnt_r + {3'h0, b2f} - {3'h0, fpop};
      end
   end

   // ************************************************************
   // serialiser on pixel clock edges
   // ************************************************************
   reg  [31:0] sh_r;
   reg  [5:0]  shn_r;
   reg  [15:0] lines_r, dots_r;
   reg         act_r;
   wire        fempty = (fcnt_r == 4'h0);
   wire        need   = (shn_r == 6'h0);
   wire        in_act = (vst_r == V_ACT) & pix_edge;
   assign fpop = in_act & need & ~fempty;
   wire [31:0] cur = need ? (fempty ? 32'h0 : fmem[rp_r]) : sh_r;
   wire [2:0]  w   = (streams == `PVEI_STR_1) ? 3'h1 :
                     (streams == `PVEI_STR_2) ? 3'h2 : 3'h4;
   wire [3:0]  bits = (w == 3'h1) ? {3'h0, cur[31]} :
                      (w == 3'h2) ? {2'h0, cur[31:30]} : cur[31:28];
   wire [15:0] step = (grey && w == 3'h4) ? 16'h1 : {13'h0, w};
   wire [2:0]  blk  = (grey && w == 3'h4) ? {2'h0, |bits} : ones4(bits);
   wire        pel_clr = wb_wr && wb_adr_i == `PVEI_REG_PEL;
   wire        urun_set = in_act & need & fempty;
   wire        urun_clr = wb_wr && wb_adr_i == `PVEI_REG_STAT &&
                          wb_sel_i[0] && wb_dat_i[`PVEI_STAT_URUN];
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         vst_r   <= V_IDLE;
         sh_r    <= 32'h0;
         shn_r   <= 6'h0;
         lines_r <= 16'h0;
         dots_r  <= 16'h0;
         act_r   <= 1'b0;
         video_o <= 4'h0;
         pel_r   <= 32'h0;
         urun_r  <= 1'b0;
         shift_clock_out_o <= 1'b0;
      end else begin
         // a dry fifo in the clearing cycle keeps the flag set
         urun_r <= urun_set | (urun_r & ~urun_clr);
         pel_r <= (pel_clr ? 32'h0 : pel_r) +
                  ((in_act && !(need && fempty)) ? {29'h0, blk} : 32'h0);
         case (vst_r)
            V_IDLE: begin
               act_r <= 1'b0;
               if (enable && page_edge) begin
                  vst_r   <= V_WAITL;
                  lines_r <= 16'h0;
               end
            end
            V_WAITL: begin
               if (line_edge) begin
                  if (lines_r < margin_r[31:16]) begin
                     lines_r <= lines_r + 16'h1;
                  end else begin
                     vst_r  <= V_HSKIP;
                     dots_r <= 16'h0;
                     shn_r  <= 6'h0;
                  end
               end
            end
            V_HSKIP: begin
               if (dots_r >= margin_r[15:0]) begin
                  vst_r  <= V_ACT;
                  dots_r <= 16'h0;
               end else if (pix_edge)
                  dots_r <= dots_r + 16'h1;
            end
            V_ACT: begin
               if (pix_edge) begin
                  video_o <= bits;
                  act_r   <= 1'b1;
                  sh_r    <= cur << w;
                  shn_r   <= (need ? `PVEI_WORD_BITS : shn_r) - {3'h0, w};
                  dots_r  <= dots_r + step;
                  if (dots_r + step >= linelen_r[15:0])
                     vst_r <= V_WAITL;
               end
            end
            default: vst_r <= V_IDLE;
         endcase
         if (vst_r != V_ACT && pix_edge) begin
            act_r   <= 1'b0;
            video_o <= 4'h0;
         end
         if (!enable) begin
            vst_r <= V_IDLE;
         end else if (page_edge && vst_r != V_IDLE) begin
            vst_r   <= V_WAITL;
            lines_r <= 16'h0;
         end
         // 4 bits per edge gives the widest rate the sampled clock allows
         case (shmode)
            `PVEI_SHM_PIX: shift_clock_out_o <= act_r & pix_r[2];
            `PVEI_SHM_INV: shift_clock_out_o <= act_r & ~pix_r[2];
            default:       shift_clock_out_o <= act_r;
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- pvei_top_asserts.sv ----
// checker for the printer video engine interface ports
`timescale 1ns/1ps
`default_nettype none
module pvei_top_asserts (
   input wire logic        clk_i,
   input wire logic        sys_rst_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_cyc_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        dma_req_o,
   input wire logic [31:0] dma_adr_o,
   input wire logic [4:0]  dma_len_o,
   input wire logic        dma_gnt_i,
   input wire logic        pixel_clock_in_i,
   input wire logic [3:0]  video_o
);
   // ************************************************************
   // pixel edge age: cycles since the raw pin was seen rising
   // ************************************************************
   logic [3:0] age_r;
   logic       pix_r;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         age_r <= 4'hf;
         pix_r <= 1'b0;
      end else begin
         pix_r <= pixel_clock_in_i;
         if (pixel_clock_in_i && !pix_r)
            age_r <= 4'h0;
         else if (age_r != 4'hf)
            age_r <= age_r + 4'h1;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // ************************************************************
   // properties
   // ************************************************************
   property p_wb_answer;
      wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##1 wb_ack_o;
   endproperty
   a_wb_answer: assert property (p_wb_answer)
      else $error("register access not answered next cycle");
   property p_wb_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_wb_pulse: assert property (p_wb_pulse)
      else $error("ack longer than one cycle");
   property p_wb_cause;
      wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
   endproperty
   a_wb_cause: assert property (p_wb_cause)
      else $error("ack without request");
   property p_wb_idle_data;
      !wb_ack_o |-> wb_dat_o == 32'h0;
   endproperty
   a_wb_idle_data: assert property (p_wb_idle_data)
      else $error("read data outside ack cycle");
   property p_dma_len;
      dma_req_o |-> dma_len_o >= 5'h01 && dma_len_o <= 5'h10;
   endproperty
   a_dma_len: assert property (p_dma_len)
      else $error("burst length outside 1 to 16 bytes");
   property p_dma_hold;
      dma_req_o && !dma_gnt_i |=> dma_req_o && $stable(dma_adr_o)
         && $stable(dma_len_o);
   endproperty
   a_dma_hold: assert property (p_dma_hold)
      else $error("burst request changed before grant");
   property p_dma_drop;
      dma_req_o && dma_gnt_i |=> !dma_req_o [*2];
   endproperty
   a_dma_drop: assert property (p_dma_drop)
      else $error("burst request kept after grant");
   property p_video_edge;
      $changed(video_o) && video_o != 4'h0 |-> age_r >= 4'h1
         && age_r <= 4'h6;
   endproperty
   a_video_edge: assert property (p_video_edge)
      else $error("video changed away from a pixel edge");
   c_burst: cover property (dma_req_o && dma_gnt_i);
endmodule
`default_nettype wire

// ---- pvei_engine_model.sv ----
// marking engine model: free pixel clock, line and page sync
`timescale 1ns/1ps
`default_nettype none
module pvei_engine_model (
   output logic pix_clk_o,
   output logic line_sync_o,
   output logic page_sync_o
);
   // oscillator runs free, every edge 0.5 ns ahead of a system clock rising edge
   initial begin
      pix_clk_o = 1'b0;
      line_sync_o = 1'b0;
      page_sync_o = 1'b0;
      #37;
      forever #100 pix_clk_o = ~pix_clk_o;
   end
   // sync pulse two pixel periods wide, launched off a falling edge
   task pulse(input logic pg);
      begin
         @(negedge pix_clk_o);
         if (pg)
            page_sync_o = 1'b1;
         else
            line_sync_o = 1'b1;
         repeat (2) @(negedge pix_clk_o);
         page_sync_o = 1'b0;
         line_sync_o = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ---- pvei_top_test.sv ----
// testbench for the printer video engine interface
`timescale 1ns/1ps
`default_nettype none
`include "pvei_consts.vh"
module pvei_top_test;
   localparam logic [31:0] WORD = 32'hf000_0001;
   logic        clk_i, sys_rst_i, wb_we_i, wb_stb_i, wb_cyc_i, dma_gnt_i;
   logic [7:0]  wb_adr_i;
   logic [31:0] wb_dat_i, rdq, n_fail, n_checks, cyc_n, nwords;
   logic [31:0] ones, early, hi, sh, cap_n;
   logic [3:0]  wb_sel_i, left, rem, nb;
   logic        dma_rvalid_i, tg, tk, g, cap_on, armed;
   logic [31:0] badr [8];
   logic [4:0]  blen [8];
   wire  [31:0] wb_dat_o, dma_adr_o, dma_rdata_i;
   wire  [4:0]  dma_len_o;
   wire  [3:0]  video_o;
   wire         wb_ack_o, dma_req_o, dma_rready_o, shift_clock_out_o;
   wire         pix, line_sync_in, page_sync_in;
   // ************************************************************
   // design, engine, memory
   // ************************************************************
   pvei_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
      .wb_we_i(wb_we_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dma_req_o(dma_req_o),
      .dma_adr_o(dma_adr_o), .dma_len_o(dma_len_o), .dma_gnt_i(dma_gnt_i),
      .dma_rdata_i(dma_rdata_i), .dma_rvalid_i(dma_rvalid_i),
      .dma_rready_o(dma_rready_o), .pixel_clock_in_i(pix),
      .line_sync_in_i(line_sync_in), .page_sync_in_i(page_sync_in), .video_o(video_o),
      .shift_clock_out_o(shift_clock_out_o));
   pvei_engine_model i_eng (.pix_clk_o(pix), .line_sync_o(line_sync_in),
      .page_sync_o(page_sync_in));
   // idle read data is scrambled so a word taken unqualified shows up
   assign dma_rdata_i = dma_rvalid_i ? WORD : ~WORD;
   // memory: grants one burst at a time, stalls every other beat
   always @(posedge clk_i) begin
      tk = dma_rvalid_i && dma_rready_o;
      rem = left - {3'h0, tk};
      g = dma_req_o && !dma_gnt_i && rem == 4'h0 && !dma_rvalid_i;
      dma_gnt_i <= g;
      tg <= ~tg;
      if (tk)
         nwords <= nwords + 32'h1;
      if (g) begin
         badr[nb[2:0]] <= dma_adr_o;
         blen[nb[2:0]] <= dma_len_o;
         nb <= nb + 4'h1;
         rem = 4'((dma_len_o + 5'h3) >> 2);
      end
      left <= rem;
      dma_rvalid_i <= rem != 4'h0 && !g && ((dma_rvalid_i && !tk) || tg);
   end
   // video sampled on the pin's rising edge, where it stands settled
   always @(posedge pix) begin
      if (cap_on && line_sync_in)
         armed = 1'b1;
      if (cap_on && armed) begin
         cap_n = cap_n + 32'h1;
         ones = ones + {31'h0, video_o[0]};
         hi = hi + {31'h0, |video_o[3:1]};
         sh = sh + {31'h0, shift_clock_out_o};
         if (cap_n <= 32'h3 && video_o[0])
            early = early + 32'h1;
      end
   end
   // ************************************************************
   // tasks
   // ************************************************************
   task check(input logic [31:0] seen, input logic [31:0] exp);
      begin
         n_checks = n_checks + 32'h1;
         if (seen !== exp) begin
            n_fail = n_fail + 32'h1;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
               seen, exp);
         end
      end
   endtask
   task wb(input logic [7:0] a, input logic we, input logic [31:0] d);
      int n;
      begin
         @(posedge clk_i);
         wb_adr_i <= a;
         wb_we_i <= we;
         wb_dat_i <= d;
         wb_sel_i <= 4'hf;
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         n = 0;
         do begin
            @(posedge clk_i);
            n++;
         end while (wb_ack_o !== 1'b1 && n < 20);
         if (wb_ack_o !== 1'b1)
            n_fail = n_fail + 32'h1;
         rdq = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         wb_we_i <= 1'b0;
      end
   endtask
   task run_line(input logic pg, input logic [31:0] edges,
                 input logic [31:0] exp_ones, input logic [31:0] exp_hi);
      begin
         if (pg)
            i_eng.pulse(1'b1);
         ones = 0;
         early = 0;
         hi = 0;
         sh = 0;
         cap_n = 0;
         armed = 1'b0;
         cap_on = 1'b1;
         i_eng.pulse(1'b0);
         wait (cap_n >= edges);
         cap_on = 1'b0;
         check(early, 32'h0);
         check(hi, exp_hi);
         if (exp_ones != 32'hffff_ffff)
            check(ones, exp_ones);
         if (exp_ones == 32'h9)
            check({31'h0, sh >= 32'd36 && sh <= 32'd44}, 32'h1);
      end
   endtask
   task summarize;
      begin
         if (n_fail == 32'h0 && n_checks != 32'h0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   // ************************************************************
   // clock, timeout, sequence
   // ************************************************************
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 32'h1;
      if (cyc_n == 32'd20000) begin
         n_fail = n_fail + 32'h1;
         summarize();
      end
   end
   initial begin : main
      logic [7:0]  ra [6];
      logic [31:0] rv [6];
      logic [31:0] ea [4];
      logic [4:0]  el [4];
      ra = '{`PVEI_REG_MARGIN, `PVEI_REG_LINELEN, `PVEI_REG_MADR,
             `PVEI_REG_MCNT, `PVEI_REG_CADR, `PVEI_REG_CCNT};
      rv = '{32'h0001_0003, 32'h28, 32'h100, 32'h28, 32'h200, 32'h4};
      ea = '{32'h100, 32'h110, 32'h120, 32'h200};
      el = '{5'h10, 5'h10, 5'h08, 5'h04};
      {sys_rst_i, wb_we_i, wb_stb_i, wb_cyc_i, dma_gnt_i} = 5'h10;
      {wb_adr_i, wb_dat_i, wb_sel_i, n_fail, n_checks, cyc_n} = '0;
      {left, nb, nwords, dma_rvalid_i, tg, cap_on, armed} = '0;
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      wb(`PVEI_REG_CTRL, 1'b0, 32'h0);
      check(rdq, {24'h0, `PVEI_CTRL_RST});
      check({27'h0, video_o, dma_req_o}, 32'h0);
      wb(8'h40, 1'b1, 32'hffff_ffff);
      wb(8'h40, 1'b0, 32'h0);
      check(rdq, 32'h0);
      for (int i = 0; i < 6; i++)
         wb(ra[i], 1'b1, rv[i]);
      wb(`PVEI_REG_MARGIN, 1'b0, 32'h0);
      check(rdq, 32'h0001_0003);
      wb(`PVEI_REG_STAT, 1'b0, 32'h0);
      check(rdq & 32'h3, 32'h3);
      wb(`PVEI_REG_CTRL, 1'b1, 32'h21);
      run_line(1'b1, 32'd60, 32'h0, 32'h0);
      run_line(1'b0, 32'd60, 32'h9, 32'h0);
      wb(`PVEI_REG_PEL, 1'b0, 32'h0);
      check(rdq, 32'h9);
      wb(`PVEI_REG_PEL, 1'b1, 32'h0);
      wb(`PVEI_REG_PEL, 1'b0, 32'h0);
      check(rdq, 32'h0);
      // long line outruns the fetched data and empties the fifo
      wb(`PVEI_REG_LINELEN, 1'b1, 32'h190);
      run_line(1'b0, 32'd420, 32'hffff_ffff, 32'h0);
      wb(`PVEI_REG_STAT, 1'b0, 32'h0);
      check(rdq & 32'h7, 32'h4);
      wb(`PVEI_REG_STAT, 1'b1, 32'h4);
      wb(`PVEI_REG_STAT, 1'b0, 32'h0);
      check(rdq & 32'h4, 32'h0);
      check({28'h0, nb}, 32'h4);
      for (int i = 0; i < 4; i++) begin
         check(badr[i], ea[i]);
         check({27'h0, blen[i]}, {27'h0, el[i]});
      end
      check(nwords, 32'd11);
      // four streams: one nibble per edge from a fresh master transfer
      wb(`PVEI_REG_CTRL, 1'b1, 32'h25);
      wb(`PVEI_REG_LINELEN, 1'b1, 32'h28);
      wb(`PVEI_REG_MADR, 1'b1, 32'h300);
      wb(`PVEI_REG_MCNT, 1'b1, 32'h10);
      wb(`PVEI_REG_PEL, 1'b1, 32'h0);
      run_line(1'b0, 32'd20, 32'h3, 32'h2);
      wb(`PVEI_REG_PEL, 1'b0, 32'h0);
      check(rdq, 32'h9);
      wb(`PVEI_REG_STAT, 1'b0, 32'h0);
      check(rdq & 32'h4, 32'h0);
      check(badr[4], 32'h300);
      summarize();
   end
endmodule
bind pvei_top pvei_top_asserts i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .dma_req_o(dma_req_o), .dma_adr_o(dma_adr_o),
   .dma_len_o(dma_len_o), .dma_gnt_i(dma_gnt_i),
   .pixel_clock_in_i(pixel_clock_in_i), .video_o(video_o));
`default_nettype wire
